// *** dpram_ctrl_pkg.sv ***
package dpram_ctrl_pkg;
  // memory shape of the widest variant
  localparam int ADDR_W = 16;                        // address pins per port
  localparam int DATA_W = 18;                        // data pins per port
  localparam int LOW_W  = 9;                         // lower lane width on 18-bit parts

  // controller register offsets (byte addresses)
  localparam logic [11:0] OFF_ADDR   = 12'h000;      // target address
  localparam logic [11:0] OFF_WDATA  = 12'h004;      // write data
  localparam logic [11:0] OFF_CMD    = 12'h008;      // command, write starts a cycle
  localparam logic [11:0] OFF_RDATA  = 12'h00c;      // last read data
  localparam logic [11:0] OFF_STATUS = 12'h010;      // live state
  localparam logic [11:0] OFF_IRQ    = 12'h014;      // sticky events, clear on read
  localparam logic [11:0] OFF_MASK   = 12'h018;      // event mask

  // command field positions
  localparam int CMD_WRITE = 0;                      // 1 write, 0 read
  localparam int CMD_SEM   = 1;                      // semaphore space
  localparam int CMD_UPPER = 2;                      // enable upper lane
  localparam int CMD_LOWER = 3;                      // enable lower lane

  // event bit positions
  localparam int EV_DONE = 0;                        // access finished
  localparam int EV_BUSY = 1;                        // contention seen
  localparam int EV_INT  = 2;                        // mailbox flag seen

  // cycle timing at 25 MHz
  localparam int CLK_NS       = 40;                  // clock period
  localparam int ACCESS_NS    = 20;                  // slowest grade access time
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;  // strobe width
  localparam int BUSY_WAIT_NS = 400;                 // longest wait for contention
  localparam int BUSY_WAIT_CYC = BUSY_WAIT_NS / CLK_NS;
  localparam logic [7:0] ACCESS_CNT = 8'(ACCESS_CYC);
  localparam logic [7:0] BUSY_CNT   = 8'(BUSY_WAIT_CYC);

  // request to the pin sequencer
  typedef struct packed {
    logic              write;
    logic              semaphore_select;
    logic              upper;
    logic              lower;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  // pins driven toward one port of the memory
  typedef struct packed {
    logic              cs_n;                         // chip_select_low_active
    logic              cs;                           // chip_select_high_active
    logic              rw;                           // 1 read, 0 write
    logic              oe_n;
    logic              sem_n;                        // semaphore_select
    logic              ub_n;                         // upper_lane_select
    logic              lb_n;                         // lower_lane_select
    logic [ADDR_W-1:0] addr;
  } pins_t;
endpackage : dpram_ctrl_pkg

// *** dpram_port_seq.sv ***
`timescale 1ns/100ps
`default_nettype none
module dpram_port_seq (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        start,
  input  wire dpram_ctrl_pkg::req_t        req,
  input  wire logic                        busy_n_in,
  input  wire logic [dpram_ctrl_pkg::DATA_W-1:0] dq_in,
  output var  dpram_ctrl_pkg::pins_t       pins,
  output var  logic [dpram_ctrl_pkg::DATA_W-1:0] dq_out,
  output var  logic [dpram_ctrl_pkg::DATA_W-1:0] dq_oe,
  output var  logic [dpram_ctrl_pkg::DATA_W-1:0] rdata,
  output var  logic                        done,
  output var  logic                        busy_seen,
  output var  logic                        idle
);
  import dpram_ctrl_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SET  = 4'b0010,
    S_STRB = 4'b0100,
    S_END  = 4'b1000
  } seq_t;

  seq_t        state_reg;                            // sequencer state
  logic [7:0]  cnt_reg;                              // strobe timer
  logic [7:0]  wait_reg;                             // contention wait timer
  req_t        req_reg;                              // latched request
  pins_t       deselect;                             // idle pin pattern
  logic [DATA_W-1:0] lane_mask;                      // lanes enabled by request

  assign deselect  = '{cs_n: 1'b1, cs: 1'b0, rw: 1'b1, oe_n: 1'b1, sem_n: 1'b1,
                       ub_n: 1'b1, lb_n: 1'b1, addr: '0};
  assign lane_mask = {{(DATA_W-LOW_W){req_reg.upper}}, {LOW_W{req_reg.lower}}};

  ////////////////////////////////////////////////////////////////////////////
  // pin sequencer: setup, strobe, release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 8'h00;
      wait_reg  <= 8'h00;
      req_reg   <= '0;
      pins      <= '{cs_n: 1'b1, cs: 1'b0, rw: 1'b1, oe_n: 1'b1, sem_n: 1'b1,
                     ub_n: 1'b1, lb_n: 1'b1, addr: '0};
      dq_out    <= '0;
      dq_oe     <= '0;
      rdata     <= '0;
      done      <= 1'b0;
      busy_seen <= 1'b0;
      idle      <= 1'b1;
    end else begin
      done      <= 1'b0;
      busy_seen <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          idle <= 1'b1;
          if (start) begin
            req_reg   <= req;
            idle      <= 1'b0;
            state_reg <= S_SET;
          end
        end
        S_SET: begin
          // both enables asserted together select the port
          pins.cs_n  <= req_reg.semaphore_select;
          pins.cs    <= ~req_reg.semaphore_select;
          pins.sem_n <= ~req_reg.semaphore_select;
          pins.addr  <= req_reg.addr;
          pins.rw    <= ~req_reg.write;
          pins.ub_n  <= ~req_reg.upper;
          pins.lb_n  <= ~req_reg.lower;
          // output enable only for reads, data driven only for writes
          pins.oe_n  <= req_reg.write;
          dq_out     <= req_reg.wdata;
          dq_oe      <= req_reg.write ? lane_mask : '0;
          cnt_reg    <= ACCESS_CNT;
          wait_reg   <= BUSY_CNT;
          state_reg  <= S_STRB;
        end
        S_STRB: begin
          // hold the strobe for up to BUSY_CNT cycles while the memory flags contention
          if (!busy_n_in && !req_reg.semaphore_select && wait_reg != 8'h00) begin
            busy_seen <= 1'b1;
            wait_reg  <= wait_reg - 8'h01;
          end else if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            // sample read data at the end of the strobe
            // writes leave the last read data alone, the bus is not driven then
            if (!req_reg.write) rdata <= (dq_in & lane_mask) | (rdata & ~lane_mask);
            state_reg <= S_END;
          end
        end
        S_END: begin
          // deselecting lets the port power down
          pins      <= deselect;
          dq_oe     <= '0;
          done      <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // a selected port always has both enables asserted together
  a_select_pair: assert property (@(posedge pclk) disable iff (!presetn)
    (pins.cs_n == 1'b0) |-> (pins.cs == 1'b1))
    else $error("chip enables not asserted as a pair");
  // never drive data while output enable is asserted
  a_no_fight: assert property (@(posedge pclk) disable iff (!presetn)
    (dq_oe != '0) |-> (pins.oe_n && !pins.rw))
    else $error("data driven during a read");
  // the port is deselected in the same cycle as done
  a_power_down: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> (pins.cs_n && !pins.cs && pins.sem_n) ##1 (pins.cs_n || !idle))
    else $error("port left selected after access");
endmodule : dpram_port_seq
`default_nettype wire

// *** dpram_ctrl.sv ***
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - select only with both chip enables asserted
// - role pin driven out as master or slave
// - upper and lower lane selects per access
// - sixteen address pins, upper unused on 32K
// - output enable for reads, drive for writes
module dpram_ctrl (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output var  logic [31:0]                         prdata,
  output var  logic                                pready,
  output var  logic                                pslverr,
  output var  logic                                irq,
  output var  dpram_ctrl_pkg::pins_t               mem_pins,
  output var  logic [dpram_ctrl_pkg::DATA_W-1:0]   dq_out,
  output var  logic [dpram_ctrl_pkg::DATA_W-1:0]   dq_oe,
  input  wire logic [dpram_ctrl_pkg::DATA_W-1:0]   dq_in,
  input  wire logic                                busy_n_in,
  input  wire logic                                int_n_in,
  output var  logic                                role_master
);
  import dpram_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [ADDR_W-1:0] addr_reg;                       // target address
  logic [DATA_W-1:0] wdata_reg;                      // write data
  logic [3:0]        cmd_reg;                        // last command bits
  logic [2:0]        irq_reg;                        // sticky events
  logic [2:0]        irq_next;                       // sticky events next value
  logic [2:0]        mask_reg;                       // event mask
  logic              int_d_reg;                      // mailbox flag, previous level
  logic              start_reg;                      // one-cycle start pulse
  logic              grant_reg;                      // last semaphore grant
  logic              role_reg;                       // master/slave choice

  // sequencer wires
  pins_t             seq_pins;
  logic [DATA_W-1:0] seq_dout;
  logic [DATA_W-1:0] seq_doe;
  logic [DATA_W-1:0] seq_rdata;
  logic              seq_done;
  logic              seq_busy;
  logic              seq_idle;
  req_t              req;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire        acc     = psel && penable;
  wire        wr_acc  = acc && pwrite;
  wire        rd_acc  = acc && !pwrite;
  wire        hit_cmd = wr_acc && paddr == OFF_CMD && seq_idle && !start_reg;
  wire        rd_irq  = rd_acc && paddr == OFF_IRQ;
  wire        mapped  = paddr == OFF_ADDR || paddr == OFF_WDATA || paddr == OFF_CMD ||
                        paddr == OFF_RDATA || paddr == OFF_STATUS || paddr == OFF_IRQ ||
                        paddr == OFF_MASK;
  wire [31:0] status  = {26'h0, role_reg, grant_reg, ~int_n_in, ~busy_n_in, ~seq_idle,
                         start_reg};
  wire [2:0]  events  = {int_d_reg & ~int_n_in, seq_busy, seq_done};

  // writes are launched even during contention; their data drive is dropped below while busy is low
  // the request carries everything one port access needs
  assign req = '{write: cmd_reg[CMD_WRITE], semaphore_select: cmd_reg[CMD_SEM],
                 upper: cmd_reg[CMD_UPPER], lower: cmd_reg[CMD_LOWER],
                 addr: addr_reg, wdata: wdata_reg};

  // clear only what the read reported; an event landing after setup survives, set wins
  assign irq_next = (rd_irq ? (irq_reg & ~prdata[2:0]) : irq_reg) | events;

  // hold writes off the pins while busy is low
  wire [DATA_W-1:0] doe_gated = (!busy_n_in && !seq_pins.rw) ? '0 : seq_doe;

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    case (a)
      OFF_ADDR:   rd_mux = {16'h0, addr_reg};
      OFF_WDATA:  rd_mux = {14'h0, wdata_reg};
      OFF_CMD:    rd_mux = {28'h0, cmd_reg};
      OFF_RDATA:  rd_mux = {14'h0, seq_rdata};
      OFF_STATUS: rd_mux = status;
      OFF_IRQ:    rd_mux = {29'h0, irq_reg};
      OFF_MASK:   rd_mux = {29'h0, mask_reg};
      default:    rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  ////////////////////////////////////////////////////////////////////////////
  // register writes; start pulse follows a command write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= '0;
      wdata_reg <= '0;
      cmd_reg   <= 4'h0;
      mask_reg  <= 3'h0;
      role_reg  <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= hit_cmd;
      if (wr_acc && paddr == OFF_ADDR)   addr_reg  <= pwdata[ADDR_W-1:0];
      if (wr_acc && paddr == OFF_WDATA)  wdata_reg <= pwdata[DATA_W-1:0];
      if (wr_acc && paddr == OFF_MASK)   mask_reg  <= pwdata[2:0];
      // role bit in status word position 5
      if (wr_acc && paddr == OFF_STATUS) role_reg  <= pwdata[5];
      // command selects memory or semaphore space
      if (hit_cmd)                       cmd_reg   <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer in the access cycle, registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux(paddr) : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events, semaphore grant and interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg   <= 3'h0;
      int_d_reg <= 1'b1;
      grant_reg <= 1'b0;
      irq       <= 1'b0;
    end else begin
      irq_reg   <= irq_next;
      // falling mailbox flag is an event
      int_d_reg <= int_n_in;
      irq       <= |(irq_next & mask_reg);
      // token held only when the readback bit is zero
      if (seq_done && cmd_reg[CMD_SEM] && !cmd_reg[CMD_WRITE]) grant_reg <= ~seq_rdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs straight from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_pins    <= '{cs_n: 1'b1, cs: 1'b0, rw: 1'b1, oe_n: 1'b1, sem_n: 1'b1,
                       ub_n: 1'b1, lb_n: 1'b1, addr: '0};
      dq_out      <= '0;
      dq_oe       <= '0;
      role_master <= 1'b0;
    end else begin
      // full sixteen address pins passed through
      mem_pins    <= seq_pins;
      dq_out      <= seq_dout;
      dq_oe       <= doe_gated;
      // role pin tells the memory whether busy is driven or sensed
      role_master <= role_reg;
    end
  end

  // per-port contention handling in the sequencer
  // contention stretches for at most BUSY_CNT cycles; the access then completes even if busy is still low
  dpram_port_seq u_seq (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (start_reg),
    .req       (req),
    .busy_n_in (busy_n_in),
    .dq_in     (dq_in),
    .pins      (seq_pins),
    .dq_out    (seq_dout),
    .dq_oe     (seq_doe),
    .rdata     (seq_rdata),
    .done      (seq_done),
    .busy_seen (seq_busy),
    .idle      (seq_idle)
  );

  // no data driven one cycle after busy seen low in a write
  a_write_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
    (!busy_n_in && !seq_pins.rw) |=> (dq_oe == '0))
    else $error("write driven during contention");
  // mailbox edge reaches the sticky bits
  a_mailbox_evt: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(int_n_in) |=> irq_reg[EV_INT])
    else $error("mailbox event lost");
  // a command write starts the sequencer next cycle
  a_cmd_start: assert property (@(posedge pclk) disable iff (!presetn)
    hit_cmd |=> start_reg ##1 !seq_idle)
    else $error("command did not start access");
  a_access_bound: assert property (@(posedge pclk) disable iff (!presetn)
    start_reg |-> ##[3:20] seq_done)
    else $error("access never finished");
  a_role_pin: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (role_master == $past(role_reg)))
    else $error("role pin stale");
  a_lane_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (!seq_pins.cs_n) |-> (seq_pins.ub_n == !cmd_reg[CMD_UPPER]))
    else $error("upper lane select wrong");
  a_pin_pair: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_pins.cs_n == !mem_pins.cs))
    else $error("memory chip enables mismatched");
  // grant reflects readback of a semaphore read
  a_sem_grant: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_done && cmd_reg[CMD_SEM] && !cmd_reg[CMD_WRITE]) |=> grant_reg == !$past(seq_rdata[0]))
    else $error("semaphore grant wrong");
endmodule : dpram_ctrl
`default_nettype wire

// *** dpram_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// behavioural model of one port of the shared memory, far port as tb inputs
module dpram_model (
  input  wire logic                                pclk,
  input  wire dpram_ctrl_pkg::pins_t               pins,
  input  wire logic [dpram_ctrl_pkg::DATA_W-1:0]   dq_out,
  input  wire logic [dpram_ctrl_pkg::DATA_W-1:0]   dq_oe,
  input  wire logic                                other_on,   // far port accessing
  input  wire logic [dpram_ctrl_pkg::ADDR_W-1:0]   other_addr, // far port address
  input  wire logic [7:0]                          other_hold, // latches held far side
  input  wire logic                                mail,       // far port posts mailbox
  output logic [dpram_ctrl_pkg::DATA_W-1:0]        dq_in,
  output logic                                     busy_n,
  output logic                                     int_n
);
  import dpram_ctrl_pkg::*;
  logic [DATA_W-1:0] mem [0:65535];  // full 64K array
  logic [7:0]        mine = 8'h00;   // latches held by this port
  logic [DATA_W-1:0] last = '0;      // last driven value
  wire sel = !pins.cs_n && pins.cs;
  wire rd  = sel && pins.rw && !pins.oe_n;
  wire srd = !pins.sem_n && pins.rw && !pins.oe_n;
  wire [2:0] si = pins.addr[2:0];
  wire [DATA_W-1:0] lm = {{9{!pins.ub_n}}, {9{!pins.lb_n}}} & dq_oe;
  wire [DATA_W-1:0] rv = srd ? {DATA_W{~mine[si]}} : mem[pins.addr];
  // released bus shows the inverse, never a stale copy
  assign dq_in = (rd || srd) ? rv : ~last;
  assign busy_n = !(sel && other_on && pins.addr == other_addr);
  assign int_n = !mail;
  //////////////////////////////////////////////////////////////////////////////
  // storage and latches, sampled each clock as the strobe is level-held
  always @(posedge pclk) begin
    if (rd || srd) begin
      last <= dq_in;
    end
    if (sel && !pins.rw && busy_n) begin
      mem[pins.addr] <= (mem[pins.addr] & ~lm) | (dq_out & lm);
    end
    if (!pins.sem_n && !pins.rw) begin
      if (dq_out[0]) begin
        mine[si] <= 1'b0;
      end else if (!other_hold[si]) begin
        mine[si] <= 1'b1;
      end
    end
  end
endmodule : dpram_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dpram_ctrl_pkg::*;
  logic              pclk = 0;
  logic              presetn = 0;
  logic              psel = 0;
  logic              penable = 0;
  logic              pwrite = 0;
  logic [11:0]       paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  pins_t             mem_pins;
  logic [DATA_W-1:0] dq_out;
  logic [DATA_W-1:0] dq_oe;
  logic [DATA_W-1:0] dq_in;
  logic              busy_n;
  logic              int_n;
  logic              role_master;
  logic              other_on = 0;
  logic [15:0]       other_addr = '0;
  logic [7:0]        other_hold = '0;
  logic              mail = 0;
  logic [31:0]       q;
  logic              err;
  int                miscompares = 0;
  int                n_tests = 0;
  dpram_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .mem_pins(mem_pins), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .busy_n_in(busy_n), .int_n_in(int_n), .role_master(role_master));
  dpram_model far (.pclk(pclk), .pins(mem_pins), .dq_out(dq_out), .dq_oe(dq_oe),
    .other_on(other_on), .other_addr(other_addr), .other_hold(other_hold), .mail(mail),
    .dq_in(dq_in), .busy_n(busy_n), .int_n(int_n));
  initial begin
    forever #20 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one apb transfer; pready, prdata and pslverr taken at the rising edge that ends it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) miscompares++;
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // start a memory cycle and poll until the sequencer is idle again
  task automatic op(input logic [3:0] cmd);
    int n;
    apb(1, OFF_CMD, {28'h0, cmd});
    repeat (3) @(posedge pclk);
    n = 0;
    do begin
      apb(0, OFF_STATUS, 0);
      n++;
    end while (q[1] !== 1'b0 && n < 40);
    if (q[1] !== 1'b0) miscompares++;
  endtask : op
  task automatic mw(input logic [15:0] a, input logic [17:0] d, input logic [3:0] cmd);
    apb(1, OFF_ADDR, {16'h0, a});
    apb(1, OFF_WDATA, {14'h0, d});
    op(cmd);
  endtask : mw
  task automatic mr(input logic [15:0] a, input logic [17:0] e, input string s);
    apb(1, OFF_ADDR, {16'h0, a});
    op(4'hc);
    apb(0, OFF_RDATA, 0);
    chk(s, {14'h0, e}, q);
  endtask : mr
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #(40 * 40000);
    miscompares++;
    give_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    chk("cs_n", 1, mem_pins.cs_n);
    chk("cs", 0, mem_pins.cs);
    chk("dq_oe", 0, dq_oe);
    presetn <= 1;
    mw(16'hffff, 18'h2a5c3, 4'hd);
    mr(16'hffff, 18'h2a5c3, "rdata_top");
    mw(16'hffff, 18'h0, 4'h5);
    mr(16'hffff, 18'h001c3, "upper_lane");
    mw(16'hffff, 18'h3ffff, 4'h9);
    mr(16'hffff, 18'h001ff, "lower_lane");
    $display("test memory done");
    mw(16'h0010, 18'h0aaaa, 4'hd);
    apb(0, OFF_IRQ, 0);
    other_on <= 1;
    other_addr <= 16'h0010;
    mw(16'h0010, 18'h15555, 4'hd);
    apb(0, OFF_IRQ, 0);
    chk("irq_busy", 32'h3, q);
    other_on <= 0;
    mr(16'h0010, 18'h0aaaa, "busy_keep");
    $display("test contention done");
    other_hold <= 8'h08;
    for (int i = 2; i < 4; i++) begin
      mw(16'(i), 18'h0, 4'hf);
      op(4'he);
      apb(0, OFF_STATUS, 0);
      chk("grant", 32'(i == 2), {31'h0, q[4]});
    end
    $display("test semaphore done");
    apb(1, OFF_MASK, 32'h4);
    apb(0, OFF_IRQ, 0);
    mail <= 1;
    repeat (4) @(posedge pclk);
    chk("irq_on", 1, irq);
    apb(0, OFF_IRQ, 0);
    chk("irq_mail", 32'h4, q);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 0, irq);
    mail <= 0;
    apb(1, OFF_MASK, 32'h0);
    mail <= 1;
    repeat (4) @(posedge pclk);
    chk("irq_mask", 0, irq);
    mail <= 0;
    $display("test mailbox done");
    apb(1, OFF_STATUS, 32'h20);
    repeat (2) @(posedge pclk);
    chk("role_on", 1, role_master);
    apb(1, OFF_STATUS, 32'h0);
    repeat (2) @(posedge pclk);
    chk("role_off", 0, role_master);
    apb(0, 12'h020, 0);
    chk("slverr", 1, err);
    chk("unmapped", 0, q);
    $display("test registers done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
